// [hdl/rtc_alarm_pkg.sv]
// Constants, types and carriers shared by the alarm and backup-mode control block.
package rtc_alarm_pkg;

    localparam int unsigned CLK_PERIOD_PS     = 25000;
    localparam int unsigned IRQ_PULSE_TIME_US = 1000;
    localparam int unsigned IRQ_PULSE_CYCLES  = IRQ_PULSE_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned PULSE_CNT_W       = 24;

    // Bus device address; the value is arbitrary.
    localparam logic [6:0]  BUS_DEV_ADDR      = 7'h52;

    localparam logic [7:0]  ADDR_ALARM_SEC    = 8'h00;
    localparam logic [7:0]  ADDR_ALARM_WDAY   = 8'h05;
    localparam logic [7:0]  ADDR_IRQ_CFG      = 8'h06;
    localparam logic [7:0]  ADDR_STATUS       = 8'h07;
    localparam logic [7:0]  ADDR_BACKUP_CFG   = 8'h08;

    localparam int unsigned NUM_FIELDS        = 6;
    localparam int unsigned FIELD_EN_BIT      = 7;
    localparam int unsigned IRQ_ALARM0_ENABLE_BIT      = 5;
    localparam int unsigned IRQ_REPEAT_BIT    = 7;
    localparam int unsigned STAT_FLAG_BIT     = 0;
    localparam int unsigned STAT_BATT_BIT     = 1;
    localparam int unsigned CFG_BSW_BIT       = 0;
    localparam int unsigned CFG_SERIAL_BUS_IN_BACKUP_CTL_BIT      = 1;

    localparam logic        BSW_RST           = 1'b1;
    localparam logic        SERIAL_BUS_IN_BACKUP_CTL_RST          = 1'b0;
    localparam logic [7:0]  ALARM_RST         = 8'h00;
    localparam logic [7:0]  IRQ_CFG_RST       = 8'h00;
    localparam logic [6:0]  BCD_SEC_ZERO      = 7'h00;

    typedef logic [7:0] byte_t;
    typedef byte_t [NUM_FIELDS-1:0] fields_t;

    // Index 0 is seconds, index 5 is weekday when cast to fields_t.
    typedef struct packed {
        byte_t wday;
        byte_t month;
        byte_t date;
        byte_t hour;
        byte_t min;
        byte_t sec;
    } time_t;

    typedef struct packed {
        logic vdd_above_reset;
        logic vdd_above_trip;
        logic vbat_above_vdd;
        logic vbat_above_trip;
    } power_t;

    // Encoded as {serial_bus_in_backup_ctl, backup_switch_select}.
    typedef enum logic [1:0] {
        MODE_A = 2'b00,
        MODE_B = 2'b01,
        MODE_C = 2'b10,
        MODE_D = 2'b11
    } backup_mode_t;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_ADDR = 3'b001,
        BS_AACK = 3'b011,
        BS_RX   = 3'b010,
        BS_RACK = 3'b110,
        BS_TX   = 3'b111,
        BS_TACK = 3'b101
    } bus_st_t;

endpackage : rtc_alarm_pkg

// [hdl/rtc_alarm_match.sv]
// Alarm-0 field comparator producing a one-cycle match event per seconds update.
`timescale 1ns/1ps
module rtc_alarm_match
    import rtc_alarm_pkg::*;
(
    input  wire logic  clk_in,       // System clock.
    input  wire logic  rst_n_in,     // Asynchronous reset, active low.
    input  wire time_t alarm_in,     // Alarm compare registers.
    input  wire time_t time_in,      // Running time, BCD.
    input  wire logic  tick_in,      // Pulse: time_in has just advanced.
    output logic       event_out     // Pulse: enabled fields match.
);

    typedef struct packed {
        logic event_q;
    } match_state_t;

    match_state_t s_q;
    match_state_t s_d;
    fields_t      a;
    fields_t      t;
    logic [NUM_FIELDS-1:0] hit;
    logic [NUM_FIELDS-1:0] en;

    assign a = fields_t'(alarm_in);
    assign t = fields_t'(time_in);

    for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_field
        assign en[i]  = a[i][FIELD_EN_BIT];
        assign hit[i] = !en[i] || (a[i][6:0] == t[i][6:0]);
    end

    always_comb begin
        s_d = s_q;
        // Without a seconds field the match is taken only at the minute rollover.
        s_d.event_q = tick_in && (&hit) && (|en)
                      && (en[0] || (t[0][6:0] == BCD_SEC_ZERO));
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign event_out = s_q.event_q;

endmodule : rtc_alarm_match

// [hdl/rtc_bus_slave.sv]
// Two-wire serial bus slave with a byte pointer, auto-increment and open-drain data.
`timescale 1ns/1ps
module rtc_bus_slave
    import rtc_alarm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = BUS_DEV_ADDR
)(
    input  wire logic  clk_in,       // System clock.
    input  wire logic  rst_n_in,     // Asynchronous reset, active low.
    input  wire logic  scl_in,       // Bus clock pin, asynchronous.
    input  wire logic  sda_in,       // Bus data pin level, asynchronous.
    input  wire logic  bus_en_in,    // High while the bus may be answered.
    output logic       sda_oe_out,   // High while pulling data low.
    output logic       wr_en_out,    // Pulse: write wr_data_out at addr_out.
    output byte_t      addr_out,     // Register pointer.
    output byte_t      wr_data_out,  // Write data.
    input  wire byte_t rd_data_in    // Read data at addr_out.
);

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        bus_st_t    st;
        byte_t      sh;
        logic [3:0] cnt;
        byte_t      ptr;
        logic       rw;
        logic       first;
        logic       nack;
        logic       drive;
        logic       wr_en;
    } bus_state_t;

    bus_state_t s_q;
    bus_state_t s_d;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;

    assign scl_rise = s_q.scl_s[1] && !s_q.scl_s[2];
    assign scl_fall = !s_q.scl_s[1] && s_q.scl_s[2];
    assign start_c  = s_q.scl_s[1] && s_q.scl_s[2] && !s_q.sda_s[1] && s_q.sda_s[2];
    assign stop_c   = s_q.scl_s[1] && s_q.scl_s[2] && s_q.sda_s[1] && !s_q.sda_s[2];

    always_comb begin
        s_d       = s_q;
        s_d.scl_s = {s_q.scl_s[1:0], scl_in};
        s_d.sda_s = {s_q.sda_s[1:0], sda_in};
        s_d.wr_en = 1'b0;
        // Step the pointer one cycle after a data write, so that the write lands first.
        if (s_q.wr_en) begin
            s_d.ptr = s_q.ptr + 8'h01;
        end
        if (!bus_en_in) begin
            s_d.st    = BS_IDLE;
            s_d.drive = 1'b0;
        end else if (stop_c) begin
            s_d.st    = BS_IDLE;
            s_d.drive = 1'b0;
        end else if (start_c) begin
            s_d.st    = BS_ADDR;
            s_d.cnt   = 4'h0;
            s_d.first = 1'b1;
            s_d.drive = 1'b0;
        end else begin
            case (s_q.st)
                BS_ADDR, BS_RX: begin
                    if (scl_rise) begin
                        s_d.sh  = {s_q.sh[6:0], s_q.sda_s[1]};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall && s_q.cnt == 4'h8) begin
                        if (s_q.st == BS_ADDR) begin
                            if (s_q.sh[7:1] == DEV_ADDR) begin
                                s_d.st    = BS_AACK;
                                s_d.rw    = s_q.sh[0];
                                s_d.drive = 1'b1;
                            end else begin
                                s_d.st = BS_IDLE;
                            end
                        end else begin
                            s_d.st    = BS_RACK;
                            s_d.drive = 1'b1;
                            if (s_q.first) begin
                                s_d.ptr   = s_q.sh;
                                s_d.first = 1'b0;
                            end else begin
                                s_d.wr_en = 1'b1;
                            end
                        end
                    end
                end
                BS_AACK, BS_RACK: begin
                    if (scl_fall) begin
                        s_d.cnt = 4'h0;
                        if (s_q.st == BS_AACK && s_q.rw) begin
                            s_d.st    = BS_TX;
                            s_d.sh    = rd_data_in;
                            s_d.drive = !rd_data_in[7];
                        end else begin
                            s_d.st    = BS_RX;
                            s_d.drive = 1'b0;
                        end
                    end
                end
                BS_TX: begin
                    if (scl_rise) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_q.cnt == 4'h8) begin
                            s_d.st    = BS_TACK;
                            s_d.drive = 1'b0;
                            s_d.ptr   = s_q.ptr + 8'h01;
                        end else begin
                            s_d.sh    = {s_q.sh[6:0], 1'b0};
                            s_d.drive = !s_q.sh[6];
                        end
                    end
                end
                BS_TACK: begin
                    if (scl_rise) begin
                        s_d.nack = s_q.sda_s[1];
                    end else if (scl_fall) begin
                        s_d.cnt = 4'h0;
                        if (s_q.nack) begin
                            s_d.st = BS_IDLE;
                        end else begin
                            s_d.st    = BS_TX;
                            s_d.sh    = rd_data_in;
                            s_d.drive = !rd_data_in[7];
                        end
                    end
                end
                default: begin
                    s_d.st    = BS_IDLE;
                    s_d.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q       <= '0;
            s_q.scl_s <= 3'h7;
            s_q.sda_s <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_oe_out  = s_q.drive;
    assign wr_en_out   = s_q.wr_en;
    assign addr_out    = s_q.ptr;
    assign wr_data_out = s_q.sh;

endmodule : rtc_bus_slave

// [hdl/rtc_alarm_backup_top.sv]
// Top of the alarm-0 and battery-backup mode control block with its register file.
`timescale 1ns/1ps
module rtc_alarm_backup_top
    import rtc_alarm_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYCLES
)(
    input  wire logic   MCLK_IN,          // System clock, 40 MHz.
    input  wire logic   ARST_N_IN,        // Asynchronous reset, active low.
    input  wire logic   SCL_IN,           // Serial bus clock pin.
    input  wire logic   SDA_IN,           // Serial bus data pin level.
    output logic        SDA_OUT,          // Data drive value, always low.
    output logic        SDA_OE_OUT,       // High while pulling data low.
    input  wire power_t POWER_IN,         // Supply comparator levels, asynchronous.
    input  wire time_t  TIME_IN,          // Running time in BCD.
    input  wire logic   SEC_TICK_IN,      // Pulse when TIME_IN advances.
    output logic        IRQ_N_OUT,        // Interrupt output, active low.
    output logic        ON_BATTERY_OUT,   // High while running from battery.
    output logic        FUNCS_ACTIVE_OUT, // High while non-timekeeping logic runs.
    output logic        BUS_ACTIVE_OUT,   // High while the bus is answered.
    output logic        ALARM0_FLAG_OUT   // Sticky alarm-0 status flag.
);

    typedef struct packed {
        power_t                 pwr_s1;
        power_t                 pwr_s2;
        time_t                  alarm;
        byte_t                  irq_cfg;
        logic                   backup_switch_select;
        logic                   serial_bus_in_backup_ctl;
        logic                   alarm0_flag;
        logic [PULSE_CNT_W-1:0] pulse_cnt;
        logic                   on_batt;
        logic                   funcs;
        logic                   bus_act;
        logic                   irq_n;
    } top_state_t;

    top_state_t   s_q;
    top_state_t   s_d;
    power_t       p;
    backup_mode_t mode;
    logic         legacy;
    logic         on_batt;
    logic         funcs;
    logic         bus_ok;
    logic         wr_en;
    byte_t        addr;
    byte_t        wr_data;
    byte_t        rd_data;
    logic         match_ev;
    logic         alarm0_enable;
    logic         interrupt_repeat_select;
    logic         al_ev;
    logic         irq_act;
    fields_t      a_arr;

    assign p                       = s_q.pwr_s2;
    assign mode                    = backup_mode_t'({s_q.serial_bus_in_backup_ctl,
                                                     s_q.backup_switch_select});
    assign legacy                  = s_q.backup_switch_select;
    assign alarm0_enable           = s_q.irq_cfg[IRQ_ALARM0_ENABLE_BIT];
    assign interrupt_repeat_select = s_q.irq_cfg[IRQ_REPEAT_BIT];

    // Supply selection and the functions that stay alive on battery.
    always_comb begin
        if (legacy) begin
            on_batt = p.vbat_above_vdd && p.vbat_above_trip;
        end else begin
            on_batt = !p.vdd_above_trip && p.vbat_above_vdd;
        end
        funcs = !(!legacy && on_batt);
    end

    // Bus availability per backup mode; a low main supply always wins.
    always_comb begin
        case (mode)
            MODE_A, MODE_C: begin
                bus_ok = p.vdd_above_reset && !on_batt;
            end
            MODE_B: begin
                bus_ok = p.vdd_above_reset;
            end
            MODE_D: begin
                bus_ok = p.vdd_above_reset && !p.vbat_above_vdd;
            end
            default: begin
                bus_ok = 1'b0;
            end
        endcase
    end

    rtc_bus_slave #(
        .DEV_ADDR    (BUS_DEV_ADDR)
    ) u_bus (
        .clk_in      (MCLK_IN),
        .rst_n_in    (ARST_N_IN),
        .scl_in      (SCL_IN),
        .sda_in      (SDA_IN),
        .bus_en_in   (s_q.bus_act),
        .sda_oe_out  (SDA_OE_OUT),
        .wr_en_out   (wr_en),
        .addr_out    (addr),
        .wr_data_out (wr_data),
        .rd_data_in  (rd_data)
    );

    rtc_alarm_match u_match (
        .clk_in      (MCLK_IN),
        .rst_n_in    (ARST_N_IN),
        .alarm_in    (s_q.alarm),
        .time_in     (TIME_IN),
        .tick_in     (SEC_TICK_IN),
        .event_out   (match_ev)
    );

    assign a_arr = fields_t'(s_q.alarm);

    always_comb begin
        rd_data = 8'h00;
        if (addr <= ADDR_ALARM_WDAY) begin
            rd_data = a_arr[addr[2:0]];
        end else if (addr == ADDR_IRQ_CFG) begin
            rd_data = s_q.irq_cfg;
        end else if (addr == ADDR_STATUS) begin
            rd_data[STAT_FLAG_BIT] = s_q.alarm0_flag;
            rd_data[STAT_BATT_BIT] = s_q.on_batt;
        end else if (addr == ADDR_BACKUP_CFG) begin
            rd_data[CFG_BSW_BIT]  = s_q.backup_switch_select;
            rd_data[CFG_SERIAL_BUS_IN_BACKUP_CTL_BIT] = s_q.serial_bus_in_backup_ctl;
        end
    end

    assign al_ev = match_ev && alarm0_enable && s_q.funcs;

    always_comb begin
        fields_t w_arr;
        w_arr      = a_arr;
        s_d        = s_q;
        s_d.pwr_s1 = POWER_IN;
        s_d.pwr_s2 = s_q.pwr_s1;
        s_d.on_batt = on_batt;
        s_d.funcs   = funcs;
        s_d.bus_act = bus_ok;
        if (wr_en) begin
            if (addr <= ADDR_ALARM_WDAY) begin
                w_arr[addr[2:0]] = wr_data;
                s_d.alarm        = time_t'(w_arr);
            end else if (addr == ADDR_IRQ_CFG) begin
                s_d.irq_cfg = wr_data;
            end else if (addr == ADDR_STATUS && !wr_data[STAT_FLAG_BIT]) begin
                s_d.alarm0_flag = 1'b0;
            end else if (addr == ADDR_BACKUP_CFG) begin
                s_d.backup_switch_select     = wr_data[CFG_BSW_BIT];
                s_d.serial_bus_in_backup_ctl = wr_data[CFG_SERIAL_BUS_IN_BACKUP_CTL_BIT];
            end
        end
        // A match in the clearing cycle still sets the flag.
        if (al_ev) begin
            s_d.alarm0_flag = 1'b1;
        end
        if (al_ev && interrupt_repeat_select) begin
            s_d.pulse_cnt = PULSE_CNT_W'(PULSE_CYCLES);
        end else if (s_q.pulse_cnt != '0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
        end
        if (interrupt_repeat_select) begin
            irq_act = s_d.pulse_cnt != '0;
        end else begin
            irq_act = s_d.alarm0_flag;
        end
        s_d.irq_n = !(irq_act && alarm0_enable && funcs);
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            s_q                          <= '0;
            s_q.alarm                    <= {NUM_FIELDS{ALARM_RST}};
            s_q.irq_cfg                  <= IRQ_CFG_RST;
            s_q.backup_switch_select     <= BSW_RST;
            s_q.serial_bus_in_backup_ctl <= SERIAL_BUS_IN_BACKUP_CTL_RST;
            s_q.funcs                    <= 1'b1;
            s_q.irq_n                    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign SDA_OUT          = 1'b0;
    assign IRQ_N_OUT        = s_q.irq_n;
    assign ON_BATTERY_OUT   = s_q.on_batt;
    assign FUNCS_ACTIVE_OUT = s_q.funcs;
    assign BUS_ACTIVE_OUT   = s_q.bus_act;
    assign ALARM0_FLAG_OUT  = s_q.alarm0_flag;

endmodule : rtc_alarm_backup_top

// [dv/rtc_alarm_backup_top_asserts.sv]
// Port-level assertions for the alarm and backup-mode control block.
`timescale 1ns/1ps
module rtc_alarm_backup_top_asserts
    import rtc_alarm_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = IRQ_PULSE_CYCLES
)(
    input wire logic   MCLK_IN,
    input wire logic   ARST_N_IN,
    input wire logic   SCL_IN,
    input wire logic   SDA_IN,
    input wire logic   SDA_OUT,
    input wire logic   SDA_OE_OUT,
    input wire power_t POWER_IN,
    input wire time_t  TIME_IN,
    input wire logic   SEC_TICK_IN,
    input wire logic   IRQ_N_OUT,
    input wire logic   ON_BATTERY_OUT,
    input wire logic   FUNCS_ACTIVE_OUT,
    input wire logic   BUS_ACTIVE_OUT,
    input wire logic   ALARM0_FLAG_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    a_bus_low_supply: assert property (
        BUS_ACTIVE_OUT |-> $past(POWER_IN.vdd_above_reset, 3))
        else $error("Bus answered below reset threshold.");
    a_bus_idle_release: assert property (
        (!BUS_ACTIVE_OUT)[*3] |-> !SDA_OE_OUT)
        else $error("Data line pulled while bus is off.");
    a_bus_std_batt: assert property (
        (ON_BATTERY_OUT && !FUNCS_ACTIVE_OUT)[*2] |-> !BUS_ACTIVE_OUT)
        else $error("Bus answered in standard backup.");
    a_batt_needs_vbat: assert property (
        ON_BATTERY_OUT |-> $past(POWER_IN.vbat_above_vdd, 3))
        else $error("Battery selected below main supply.");
    a_funcs_off_batt: assert property (
        !FUNCS_ACTIVE_OUT |-> ON_BATTERY_OUT && $past(!POWER_IN.vdd_above_trip, 3))
        else $error("Functions stopped while not on battery.");
    a_flag_after_tick: assert property (
        $rose(ALARM0_FLAG_OUT) |-> $past(SEC_TICK_IN, 2))
        else $error("Alarm flag set without a seconds update.");
    a_irq_with_flag: assert property (
        $fell(IRQ_N_OUT) |-> ALARM0_FLAG_OUT && $past(SEC_TICK_IN, 2))
        else $error("Interrupt asserted without a flagged match.");
    a_irq_needs_funcs: assert property (
        $fell(IRQ_N_OUT) |-> FUNCS_ACTIVE_OUT)
        else $error("Interrupt raised while functions were stopped.");
    c_irq_fall: cover property ($fell(IRQ_N_OUT));
    c_batt_bus: cover property (ON_BATTERY_OUT && BUS_ACTIVE_OUT);
    c_std_off: cover property (!FUNCS_ACTIVE_OUT);
endmodule : rtc_alarm_backup_top_asserts

// [dv/rtc_bus_host.sv]
// Two-wire bus master model standing in for the host processor.
`timescale 1ns/1ps
module rtc_bus_host
    import rtc_alarm_pkg::*;
(
    output logic      scl_out,    // Bus clock, idle high.
    output logic      sda_oe_out, // High while pulling data low.
    input  wire logic sda_in      // Resolved data wire level.
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // The long low phase lets the slave drop its acknowledge before a repeated start.
    task automatic start_cond();
        #50 sda_oe_out = 1'b0;
        #100 scl_out = 1'b1;
        #100 sda_oe_out = 1'b1;
        #100 scl_out = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #50 sda_oe_out = 1'b1;
        #100 scl_out = 1'b1;
        #100 sda_oe_out = 1'b0;
        #100;
    endtask : stop_cond
    task automatic bit_io(input logic b, output logic r);
        #50 sda_oe_out = !b;
        #50 scl_out = 1'b1;
        #100 r = sda_in;
        scl_out = 1'b0;
    endtask : bit_io
    task automatic byte_io(input byte_t tx, input logic ack_in, output byte_t rx,
                           output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack_out);
    endtask : byte_io
    task automatic wr(input byte_t a, input byte_t d, output logic nak);
        byte_t r;
        logic  n0, n1, n2;
        start_cond();
        byte_io({BUS_DEV_ADDR, 1'b0}, 1'b1, r, n0);
        byte_io(a, 1'b1, r, n1);
        byte_io(d, 1'b1, r, n2);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : wr
    task automatic rd(input byte_t a, output byte_t d, output logic nak);
        byte_t r;
        logic  n0, n1, n2, n3;
        start_cond();
        byte_io({BUS_DEV_ADDR, 1'b0}, 1'b1, r, n0);
        byte_io(a, 1'b1, r, n1);
        start_cond();
        byte_io({BUS_DEV_ADDR, 1'b1}, 1'b1, r, n2);
        byte_io(8'hff, 1'b1, d, n3);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : rd
endmodule : rtc_bus_host

// [dv/rtc_alarm_backup_top_tb.sv]
// Self-checking bench for the alarm and backup-mode control block.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module rtc_alarm_backup_top_tb;
    import rtc_alarm_pkg::*;
    localparam int unsigned PULSE = 20;
    logic   mclk = 1'b0;
    logic   arst_n = 1'b0;
    logic   tick = 1'b0;
    logic   scl, host_oe, sda_wire, sda_out, sda_oe, irq_n, on_batt, funcs, bus_act, flag;
    power_t pwr = 4'hd;
    time_t  tnow = '0;
    int     bad_count = 0;
    int     tests_run = 0;
    always #12.5 mclk = ~mclk;
    assign sda_wire = !(host_oe || sda_oe);
    rtc_alarm_backup_top #(.PULSE_CYCLES(PULSE)) dut (
        .MCLK_IN(mclk), .ARST_N_IN(arst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
        .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .POWER_IN(pwr), .TIME_IN(tnow),
        .SEC_TICK_IN(tick), .IRQ_N_OUT(irq_n), .ON_BATTERY_OUT(on_batt),
        .FUNCS_ACTIVE_OUT(funcs), .BUS_ACTIVE_OUT(bus_act), .ALARM0_FLAG_OUT(flag));
    rtc_bus_host host (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda_wire));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : cyc
    task automatic wreg(input byte_t a, input byte_t d);
        logic n;
        host.wr(a, d, n);
        `CHK(n, 1'b0)
    endtask : wreg
    task automatic chk_reg(input byte_t a, input byte_t e);
        byte_t d;
        logic  n;
        host.rd(a, d, n);
        `CHK({n, d}, {1'b0, e})
    endtask : chk_reg
    function automatic time_t tm(input byte_t mo, input byte_t hr, input byte_t se);
        return {8'h03, mo, 8'h01, hr, 8'h30, se};
    endfunction : tm
    task automatic tick_at(input time_t t);
        cyc(1);
        tnow = t;
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(2);
    endtask : tick_at
    task automatic t_reset();
        `CHK({bus_act, on_batt, funcs, flag, irq_n}, 5'b10101)
        chk_reg(ADDR_BACKUP_CFG, 8'h01);
        chk_reg(ADDR_ALARM_SEC, ALARM_RST);
        chk_reg(ADDR_IRQ_CFG, IRQ_CFG_RST);
        wreg(8'h20, 8'h5a);
        chk_reg(8'h20, 8'h00);
    endtask : t_reset
    task automatic t_single();
        wreg(8'h01, 8'hb0);
        wreg(8'h02, 8'h91);
        wreg(8'h03, 8'h81);
        wreg(8'h04, 8'h81);
        wreg(ADDR_IRQ_CFG, 8'h20);
        tick_at(tm(8'h02, 8'h11, 8'h00));
        `CHK(flag, 1'b0)
        tick_at(tm(8'h01, 8'h11, 8'h01));
        `CHK(flag, 1'b0)
        tick_at(tm(8'h01, 8'h11, 8'h00));
        `CHK({flag, irq_n}, 2'b10)
        cyc(PULSE + 5);
        `CHK(irq_n, 1'b0)
        wreg(ADDR_STATUS, 8'h00);
        `CHK({flag, irq_n}, 2'b01)
        wreg(ADDR_IRQ_CFG, 8'h00);
        tick_at(tm(8'h01, 8'h11, 8'h00));
        `CHK({flag, irq_n}, 2'b01)
    endtask : t_single
    task automatic t_repeat();
        wreg(ADDR_ALARM_SEC, 8'hb0);
        for (int i = 1; i < 5; i++) begin
            wreg(i[7:0], 8'h00);
        end
        wreg(ADDR_IRQ_CFG, 8'ha0);
        for (int k = 0; k < 2; k++) begin
            tick_at(tm(8'h01, 8'h11, 8'h31));
            `CHK(irq_n, 1'b1)
            tick_at(tm(8'h01, 8'h11, 8'h30));
            `CHK({flag, irq_n}, 2'b10)
            cyc(PULSE - 2);
            `CHK(irq_n, 1'b0)
            cyc(2);
            `CHK(irq_n, 1'b1)
        end
    endtask : t_repeat
    task automatic t_modes();
        logic n;
        for (int m = 0; m < 4; m++) begin
            wreg(ADDR_BACKUP_CFG, m[7:0]);
            pwr = 4'hb;
            cyc(6);
            `CHK({on_batt, funcs, bus_act}, {1'b1, m[0], m == 1})
            pwr = 4'hd;
            cyc(6);
            `CHK(bus_act, 1'b1)
        end
        wreg(ADDR_BACKUP_CFG, 8'h01);
        pwr = 4'h3;
        cyc(6);
        `CHK(bus_act, 1'b0)
        `CHK({sda_out, sda_oe}, 2'b00)
        host.wr(ADDR_IRQ_CFG, 8'h00, n);
        `CHK(n, 1'b1)
        pwr = 4'hd;
        cyc(6);
    endtask : t_modes
    task automatic t_mid_reset();
        wreg(ADDR_BACKUP_CFG, 8'h02);
        chk_reg(ADDR_BACKUP_CFG, 8'h02);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        cyc(10);
        `CHK({flag, irq_n}, 2'b01)
        chk_reg(ADDR_BACKUP_CFG, 8'h01);
    endtask : t_mid_reset
    task automatic final_report();
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge mclk);
        #2 arst_n = 1'b1;
        cyc(10);
        t_reset();
        t_single();
        t_repeat();
        t_modes();
        t_mid_reset();
        final_report();
    end
    initial begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule : rtc_alarm_backup_top_tb
bind rtc_alarm_backup_top rtc_alarm_backup_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk (
    .MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .POWER_IN(POWER_IN), .TIME_IN(TIME_IN),
    .SEC_TICK_IN(SEC_TICK_IN), .IRQ_N_OUT(IRQ_N_OUT), .ON_BATTERY_OUT(ON_BATTERY_OUT),
    .FUNCS_ACTIVE_OUT(FUNCS_ACTIVE_OUT), .BUS_ACTIVE_OUT(BUS_ACTIVE_OUT),
    .ALARM0_FLAG_OUT(ALARM0_FLAG_OUT));
